// ### rtl/lsxt_defines.svh
`ifndef LSXT_DEFINES_SVH
`define LSXT_DEFINES_SVH

// ==========================================================
// Register map
`define LSXT_PIN_LEVEL_ADDR   20'hF208
`define LSXT_INPUT_EN_ADDR    20'hF209

// ==========================================================
// Field positions and reset values
`define LSXT_INPUT_EN_BIT     0
`define LSXT_FIRST_LEVEL_BIT  0
`define LSXT_SECOND_LEVEL_BIT 1
`define LSXT_INPUT_EN_RST     8'h00
`define LSXT_LEVEL_OFF_VAL    2'h0
`define LSXT_RDATA_RST        8'h00

// ==========================================================
// Oscillator mode field codes
`define LSXT_MODE_XTAL        2'h1
`define LSXT_MODE_GPIN        2'h2
`define LSXT_MODE_EXTCLK      2'h3

`endif

// ### rtl/lsxt_pkg.sv
package lsxt_pkg;

    // ======================================================
    // Pin role, one-hot
    typedef enum logic [3:0] {
        LSXT_ROLE_IDLE   = 4'h1,
        LSXT_ROLE_XTAL   = 4'h2,
        LSXT_ROLE_EXTCLK = 4'h4,
        LSXT_ROLE_GPIN   = 4'h8
    } lsxt_role_t;

endpackage

// ### rtl/lsxt_role_dec.sv
`timescale 1ns/1ps
`include "lsxt_defines.svh"

module lsxt_role_dec (
    input  wire logic             input_en,
    input  wire logic [1:0]       osc_mode,
    output lsxt_pkg::lsxt_role_t  role,
    output logic                  first_buf_en,
    output logic                  second_buf_en
);

    // ======================================================
    // Role decode
    always_comb begin
        // Enable wins; mismatched modes leave pins idle
        if (input_en) begin
            if (osc_mode == `LSXT_MODE_GPIN) begin
                role = lsxt_pkg::LSXT_ROLE_GPIN;
            end else begin
                role = lsxt_pkg::LSXT_ROLE_IDLE;
            end
        end else if (osc_mode == `LSXT_MODE_XTAL) begin
            role = lsxt_pkg::LSXT_ROLE_XTAL;
        end else if (osc_mode == `LSXT_MODE_EXTCLK) begin
            role = lsxt_pkg::LSXT_ROLE_EXTCLK;
        end else begin
            role = lsxt_pkg::LSXT_ROLE_IDLE;
        end
    end

    // ======================================================
    // Input buffers follow one bit for both pins
    always_comb begin
        first_buf_en  = input_en;
        second_buf_en = input_en;
    end

endmodule // lsxt_role_dec

// ### rtl/lsxt_port.sv
`timescale 1ns/1ps
`include "lsxt_defines.svh"

// Function
// - Level register bits 1 and 0 show second and first pin levels.
// - Level register is read-only, eight bits, upper six read zero.
// - Enable bit 0 gates both input buffers together; resets to 0.
// - After reset both pin inputs stay disabled until software enables.
// - With inputs enabled, level reads reflect present pin levels.
// - Enable 0 with mode 1 gives both pins to the crystal.
// - Enable 0 with mode 3: second pin clock in, first disabled.
// - Input use needs enable 1 only; interrupt use needs enable 1, mode 2, pin selected.

module lsxt_port (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [19:0] sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        osc_mode_field_hi,
    input  wire logic        osc_mode_field_lo,
    input  wire logic [1:0]  ext_irq_select_reg,
    input  wire logic        first_osc_pin,
    input  wire logic        second_osc_pin,
    output logic             first_buf_en,
    output logic             second_buf_en,
    output logic             xtal_osc_en,
    output logic             low_speed_clock_in,
    output logic             ext_irq_in_a,
    output logic             ext_irq_in_b
);

    // ======================================================
    // Declarations
    logic [7:0]           input_en_q;
    logic [7:0]           input_en_d;
    logic [1:0]           level_q;
    logic [1:0]           level_d;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;
    logic [1:0]           osc_mode;
    logic                 both_pin_input_en;
    lsxt_pkg::lsxt_role_t role;

    assign osc_mode          = {osc_mode_field_hi, osc_mode_field_lo};
    assign both_pin_input_en = input_en_q[`LSXT_INPUT_EN_BIT];

    // ======================================================
    // Address decode
    function automatic logic hit(input logic [19:0] a,
                                 input logic [19:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // ======================================================
    // Role decoder
    lsxt_role_dec u_role_dec (
        .input_en      (both_pin_input_en),
        .osc_mode      (osc_mode),
        .role          (role),
        .first_buf_en  (first_buf_en),
        .second_buf_en (second_buf_en)
    );

    // ======================================================
    // Input enable register
    always_comb begin
        input_en_d = input_en_q;
        // Upper bits are storage only
        if (sfr_wr && hit(sfr_addr, `LSXT_INPUT_EN_ADDR)) begin
            input_en_d = sfr_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            input_en_q <= `LSXT_INPUT_EN_RST;
        end else begin
            input_en_q <= input_en_d;
        end
    end

    // ======================================================
    // Pin level capture
    always_comb begin
        // Floating pads must not reach software
        if (both_pin_input_en) begin
            level_d = {second_osc_pin, first_osc_pin};
        end else begin
            level_d = `LSXT_LEVEL_OFF_VAL;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_q <= `LSXT_LEVEL_OFF_VAL;
        end else begin
            level_q <= level_d;
        end
    end

    // ======================================================
    // Read data
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            if (hit(sfr_addr, `LSXT_PIN_LEVEL_ADDR)) begin
                rdata_d = {6'h00, level_q};
            end else if (hit(sfr_addr, `LSXT_INPUT_EN_ADDR)) begin
                rdata_d = input_en_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `LSXT_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;

    // ======================================================
    // Pin roles toward the clock and interrupt blocks
    always_comb begin
        xtal_osc_en        = 1'b0;
        low_speed_clock_in = 1'b0;
        ext_irq_in_a       = 1'b0;
        ext_irq_in_b       = 1'b0;
        unique case (role)
            lsxt_pkg::LSXT_ROLE_IDLE: begin
                xtal_osc_en = 1'b0;
            end
            lsxt_pkg::LSXT_ROLE_XTAL: begin
                xtal_osc_en = 1'b1;
            end
            lsxt_pkg::LSXT_ROLE_EXTCLK: begin
                // Clock path bypasses the gated buffer
                low_speed_clock_in = second_osc_pin;
            end
            lsxt_pkg::LSXT_ROLE_GPIN: begin
                ext_irq_in_a = level_q[`LSXT_FIRST_LEVEL_BIT]
                               & ext_irq_select_reg[0];
                ext_irq_in_b = level_q[`LSXT_SECOND_LEVEL_BIT]
                               & ext_irq_select_reg[1];
            end
        endcase
    end

    // ======================================================
    // Checks
    a_level_read: assert property (
        @(posedge clock) disable iff (!rstn)
        (sfr_rd && sfr_addr == `LSXT_PIN_LEVEL_ADDR)
        |=> sfr_rdata[1:0] == $past(level_q))
        else $error("Level read does not show pins");

    a_level_upper_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        (sfr_rd && sfr_addr == `LSXT_PIN_LEVEL_ADDR)
        |=> sfr_rdata[7:2] == 6'h00)
        else $error("Level upper bits not zero");

    a_level_no_write: assert property (
        @(posedge clock) disable iff (!rstn)
        (sfr_wr && sfr_addr == `LSXT_PIN_LEVEL_ADDR)
        |=> input_en_q == $past(input_en_q))
        else $error("Level write changed state");

    a_enable_write: assert property (
        @(posedge clock) disable iff (!rstn)
        (sfr_wr && sfr_addr == `LSXT_INPUT_EN_ADDR)
        |=> (first_buf_en == $past(sfr_wdata[0]))
            && (second_buf_en == first_buf_en))
        else $error("Enable write not applied to both pins");

    a_reset_disabled: assert property (
        @(posedge clock)
        $rose(rstn) |-> (!first_buf_en && !second_buf_en
                         && level_q == 2'h0))
        else $error("Inputs enabled after reset");

    a_level_present: assert property (
        @(posedge clock) disable iff (!rstn)
        both_pin_input_en
        |=> level_q == {$past(second_osc_pin), $past(first_osc_pin)})
        else $error("Enabled level is stale");

    a_xtal_role: assert property (
        @(posedge clock) disable iff (!rstn)
        (!both_pin_input_en && osc_mode == `LSXT_MODE_XTAL)
        |-> (xtal_osc_en && !first_buf_en && !second_buf_en
             && !ext_irq_in_a && !ext_irq_in_b))
        else $error("Crystal role wrong");

    a_extclk_role: assert property (
        @(posedge clock) disable iff (!rstn)
        (!both_pin_input_en && osc_mode == `LSXT_MODE_EXTCLK)
        |-> (low_speed_clock_in == second_osc_pin
             && !first_buf_en && !xtal_osc_en))
        else $error("External clock role wrong");

    a_irq_gate: assert property (
        @(posedge clock) disable iff (!rstn)
        (ext_irq_in_a || ext_irq_in_b)
        |-> (both_pin_input_en && osc_mode == `LSXT_MODE_GPIN
             && (ext_irq_in_a ? ext_irq_select_reg[0] : 1'b1)
             && (ext_irq_in_b ? ext_irq_select_reg[1] : 1'b1)))
        else $error("Interrupt input outside its mode");

    a_level_forced: assert property (
        @(posedge clock) disable iff (!rstn)
        !both_pin_input_en |=> level_q == 2'h0)
        else $error("Disabled level not forced");

endmodule // lsxt_port

// ### tb/lsxt_pin_src.sv
`timescale 1ns/1ps

module lsxt_pin_src (
    input  wire logic       clock,
    input  wire logic [1:0] src,
    input  wire logic [1:0] lvl,
    output logic            first_osc_pin,
    output logic            second_osc_pin
);
    // ==========================================================
    // Oscillation phase
    // Free running, as a crystal does not stop between frames
    logic ph_q = 1'b0;

    always @(posedge clock) begin
        ph_q <= ~ph_q;
    end

    // Src 1: crystal in antiphase on both pins
    // Src 2: clock on second pin, first pin strapped outside
    always_comb begin
        first_osc_pin  = lvl[0];
        second_osc_pin = lvl[1];
        if (src == 2'h1) begin
            first_osc_pin  = ph_q;
            second_osc_pin = ~ph_q;
        end else if (src == 2'h2) begin
            second_osc_pin = ph_q;
        end
    end
endmodule // lsxt_pin_src

// ### tb/low_speed_osc_input_port_tb.sv
`timescale 1ns/1ps

module low_speed_osc_input_port_tb;
    typedef struct packed {
        logic       en;
        logic [1:0] mode, sel, lvl, src, e_lvl;
        logic       e_xt;
        logic [1:0] e_irq;
    } lsxt_row_t;

    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [19:0] sfr_addr = 20'h00000;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata, rv;
    logic [1:0]  mode = 2'h2;
    logic [1:0]  sel = 2'h3;
    logic [1:0]  lvl = 2'h3;
    logic [1:0]  src = 2'h0;
    logic        first_osc_pin, second_osc_pin, first_buf_en;
    logic        second_buf_en, xtal, lsclk, irq_a, irq_b;
    int          err_total = 0;
    int          samples_checked = 0;
    lsxt_row_t   rows [8] = '{
        '{1'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 1'h0, 2'h1},
        '{1'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h2, 1'h0, 2'h2},
        '{1'h1, 2'h2, 2'h1, 2'h3, 2'h0, 2'h3, 1'h0, 2'h1},
        '{1'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h3, 1'h0, 2'h0},
        '{1'h0, 2'h1, 2'h3, 2'h3, 2'h1, 2'h0, 1'h1, 2'h0},
        '{1'h0, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0, 1'h0, 2'h0},
        '{1'h1, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 1'h0, 2'h0},
        '{1'h0, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 1'h0, 2'h0}};

    always #12.5 clock = ~clock;

    lsxt_pin_src PM (.clock(clock), .src(src), .lvl(lvl),
        .first_osc_pin(first_osc_pin), .second_osc_pin(second_osc_pin));

    lsxt_port DUT (.clock(clock), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .osc_mode_field_hi(mode[1]),
        .osc_mode_field_lo(mode[0]), .ext_irq_select_reg(sel),
        .first_osc_pin(first_osc_pin), .second_osc_pin(second_osc_pin),
        .first_buf_en(first_buf_en), .second_buf_en(second_buf_en),
        .xtal_osc_en(xtal), .low_speed_clock_in(lsclk),
        .ext_irq_in_a(irq_a), .ext_irq_in_b(irq_b));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        chk("buf_rst", {6'h00, second_buf_en, first_buf_en}, 8'h00);
        @(negedge clock);
        rstn = 1'b1;
        rd(20'hF209, rv);
        chk("en_rst", rv, 8'h00);
        rd(20'hF208, rv);
        chk("lvl_rst", rv, 8'h00);
        foreach (rows[i]) begin
            // Enable settled before the pins change role
            wr(20'hF209, {7'h00, rows[i].en});
            @(negedge clock);
            mode = rows[i].mode;
            sel = rows[i].sel;
            lvl = rows[i].lvl;
            src = rows[i].src;
            rd(20'hF208, rv);
            chk("level", rv, {6'h00, rows[i].e_lvl});
            chk("buf_en", {6'h00, second_buf_en, first_buf_en},
                {6'h00, {2{rows[i].en}}});
            chk("xtal", {7'h00, xtal}, {7'h00, rows[i].e_xt});
            chk("lsclk", {7'h00, lsclk},
                {7'h00, !rows[i].en && mode == 2'h3 && second_osc_pin});
            chk("irq", {6'h00, irq_b, irq_a},
                {6'h00, rows[i].e_irq});
        end
        // Upper enable bits are plain storage; unmapped write ignored
        wr(20'hF209, 8'hA5);
        wr(20'hF20A, 8'h00);
        rd(20'hF209, rv);
        chk("en_rw", rv, 8'hA5);
        lvl = 2'h2;
        wr(20'hF208, 8'hFF);
        rd(20'hF208, rv);
        chk("lvl_ro", rv, 8'h02);
        lvl = 2'h1;
        rd(20'hF208, rv);
        chk("lvl_now", rv, 8'h01);
        rd(20'hF20A, rv);
        chk("unmapped", rv, 8'h00);
        // Reset in mid-run drops the enable again
        @(negedge clock);
        rstn = 1'b0;
        @(negedge clock);
        chk("buf_rst2", {6'h00, second_buf_en, first_buf_en},
            8'h00);
        rstn = 1'b1;
        rd(20'hF209, rv);
        chk("en_rst2", rv, 8'h00);
        rd(20'hF208, rv);
        chk("lvl_rst2", rv, 8'h00);
        print_verdict();
    end

    // Run needs about 75 cycles
    initial begin
        #(25 * 1000);
        err_total++;
        print_verdict();
    end
endmodule // low_speed_osc_input_port_tb
